// file: include/uart_rx_pkg.sv
package uart_rx_pkg;
    // Register offsets on the plain register port.
    localparam logic [2:0] MODE_OFS    = 3'h0;
    localparam logic [2:0] ERR_OFS     = 3'h1;
    localparam logic [2:0] BUF_OFS     = 3'h2;
    localparam logic [2:0] DIV_OFS     = 3'h3;
    localparam logic [2:0] CLKSEL_OFS  = 3'h4;
    localparam logic [2:0] CTRL_OFS    = 3'h5;
    // Fields of operation_mode_reg.
    localparam int POWER_BIT   = 7;
    localparam int RXEN_BIT    = 5;
    localparam int PAR_HI_BIT  = 4;
    localparam int PAR_LO_BIT  = 3;
    localparam int LEN8_BIT    = 2;
    localparam int MERGE_BIT   = 0;
    // Fields of rx_error_status_reg.
    localparam int OVE_BIT     = 0;
    localparam int FE_BIT      = 1;
    localparam int PE_BIT      = 2;
    // Fields of serial_control_reg.
    localparam int BRK_FLAG_BIT = 7;
    localparam int BRK_TRIG_BIT = 6;
    localparam int LSB_BIT      = 1;
    // Parity selections.
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ZERO = 2'h1;
    localparam logic [1:0] PAR_ODD  = 2'h2;
    localparam logic [1:0] PAR_EVEN = 2'h3;
    // Values after reset.
    localparam logic [7:0] MODE_RST   = 8'h01;
    localparam logic [7:0] BUF_RST    = 8'hff;
    localparam logic [7:0] DIV_RST    = 8'hff;
    localparam logic [3:0] CLKSEL_RST = 4'h0;
    localparam logic [1:0] CTRL_RST   = 2'h0;
    // Prescaler, break and data length figures.
    localparam int          PRE_W      = 10;
    localparam logic [3:0]  PRE_MAX    = 4'ha;
    localparam logic [3:0]  BRK_MIN    = 4'hb;
    localparam logic [3:0]  BRK_SAT    = 4'hf;
    localparam logic [2:0]  LAST_BIT8  = 3'h7;
    localparam logic [2:0]  LAST_BIT7  = 3'h6;
    // Receiver states.
    typedef enum logic [2:0] {
        IDLE, START, DATA, PARITY, STOP, BRK
    } rx_state_e;
endpackage : uart_rx_pkg

// file: design/base_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
module base_prescaler (
    // Clock and reset.
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    // Control.
    input  wire logic       power_in,
    input  wire logic [3:0] select_in,
    // Base clock enable.
    output logic            base_tick_out
);
    import uart_rx_pkg::*;

    typedef struct packed {
        logic [PRE_W-1:0] cnt;
    } pre_s;

    pre_s             s_r;
    pre_s             s_nxt;
    logic [3:0]       sel_c;
    logic [PRE_W-1:0] mask_c;

    // Selections past the top divide ratio use the top ratio.
    assign sel_c  = (select_in > PRE_MAX) ? PRE_MAX : select_in;
    assign mask_c = PRE_W'((11'h1 << sel_c) - 11'h1);
    assign base_tick_out = power_in && ((s_r.cnt & mask_c) == mask_c);

    // The base clock stands still while the port is off.
    always_comb begin
        s_nxt = s_r;
        s_nxt.cnt = power_in ? s_r.cnt + PRE_W'(1) : '0;
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : base_prescaler
`default_nettype wire

// file: design/uart_receiver.sv
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module uart_receiver (
    // Clock and reset.
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    // Register port.
    input  wire logic [2:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic [7:0]      reg_rdata_out,
    // Serial line.
    input  wire logic       serial_in_pin_in,
    // Interrupt requests.
    output logic            rx_done_irq_out,
    output logic            rx_error_irq_out
);
    import uart_rx_pkg::*;

    typedef struct packed {
        rx_state_e  state;
        logic       samp;
        logic       level;
        logic       prev;
        logic [7:0] cnt;
        logic       half;
        logic [2:0] bit_idx;
        logic       par_acc;
        logic       par_bad;
        logic [3:0] low_cnt;
        logic [7:0] rx_shift_reg;
        logic [7:0] rx_buffer_reg;
        logic       buf_full;
        logic [2:0] err;
        logic [7:0] operation_mode_reg;
        logic [7:0] baud_divisor_reg;
        logic [3:0] base_clock_select_reg;
        logic       break_rx_trigger;
        logic       break_rx_flag;
        logic       lsb_first;
        logic [7:0] rdata;
        logic       done_irq;
        logic       err_irq;
    } rx_s;

    rx_s        s_r;
    rx_s        s_nxt;
    logic       base_tick;
    logic       enabled;
    logic       cnt_hit;
    logic       sample_ev;
    logic       fall;
    logic [1:0] par_mode;
    logic [2:0] last_bit;
    logic       rd_err;
    logic       rd_buf;
    logic       serial_in_pin;

    // The receiver only looks at the line when fully switched on.
    assign enabled = s_r.operation_mode_reg[POWER_BIT]
                  && s_r.operation_mode_reg[RXEN_BIT];
    assign par_mode = s_r.operation_mode_reg[PAR_HI_BIT:PAR_LO_BIT];
    assign last_bit = s_r.operation_mode_reg[LEN8_BIT] ? LAST_BIT8
                                                       : LAST_BIT7;
    assign cnt_hit = base_tick
                  && (s_r.cnt == s_r.baud_divisor_reg - 8'h01);
    // Start is checked after k ticks, each later bit after 2k ticks.
    assign sample_ev = enabled && cnt_hit
                    && (s_r.state == START || s_r.half);
    assign fall = s_r.prev && !s_r.level;
    assign rd_err = reg_rd_in && reg_addr_in == ERR_OFS;
    assign rd_buf = reg_rd_in && reg_addr_in == BUF_OFS;
    assign serial_in_pin = serial_in_pin_in;

    assign reg_rdata_out    = s_r.rdata;
    assign rx_done_irq_out  = s_r.done_irq;
    assign rx_error_irq_out = s_r.err_irq;

    // Base clock: source selector in front of the 8-bit counter.
    base_prescaler u_pre (
        .clock_in      (clock_in),
        .rst_n_in      (rst_n_in),
        .power_in      (s_r.operation_mode_reg[POWER_BIT]),
        .select_in     (s_r.base_clock_select_reg),
        .base_tick_out (base_tick)
    );

    // Whole receiver: registers, filter, bit timing and frame sequence.
    always_comb begin
        logic [2:0] new_err;
        logic       done;
        new_err = 3'h0;
        done    = 1'b0;
        s_nxt = s_r;
        s_nxt.done_irq = 1'b0;
        s_nxt.err_irq  = 1'b0;

        // Noise filter and bit timing run on the base clock.
        if (!enabled) begin
            s_nxt.state = IDLE;
            s_nxt.cnt   = 8'h00;
            s_nxt.half  = 1'b0;
        end else if (base_tick) begin
            s_nxt.samp = serial_in_pin;
            if (s_r.samp == serial_in_pin) begin
                s_nxt.level = serial_in_pin;
            end
            s_nxt.prev = s_r.level;
            if (s_r.state == IDLE) begin
                s_nxt.cnt = 8'h00;
                if (fall) begin
                    s_nxt.state = START;
                end
            end else if (cnt_hit) begin
                s_nxt.cnt  = 8'h00;
                s_nxt.half = (s_r.state == START) ? 1'b0 : !s_r.half;
            end else begin
                s_nxt.cnt = s_r.cnt + 8'h01;
            end
        end

        // Frame sequence, one step per mid-bit sample.
        if (sample_ev) begin
            unique case (s_r.state)
                START: begin
                    if (s_r.level) begin
                        s_nxt.state = IDLE;
                    end else if (s_r.break_rx_trigger) begin
                        s_nxt.state         = BRK;
                        s_nxt.break_rx_flag = 1'b1;
                        s_nxt.low_cnt       = 4'h1;
                    end else begin
                        s_nxt.state   = DATA;
                        s_nxt.bit_idx = 3'h0;
                        s_nxt.par_acc = 1'b0;
                    end
                end
                DATA: begin
                    s_nxt.par_acc = s_r.par_acc ^ s_r.level;
                    s_nxt.rx_shift_reg = s_r.lsb_first
                        ? {s_r.level, s_r.rx_shift_reg[7:1]}
                        : {s_r.rx_shift_reg[6:0], s_r.level};
                    s_nxt.bit_idx = s_r.bit_idx + 3'h1;
                    if (s_r.bit_idx == last_bit) begin
                        s_nxt.state = (par_mode == PAR_NONE) ? STOP
                                                             : PARITY;
                    end
                end
                PARITY: begin
                    // Mismatch is held until the frame ends.
                    unique case (par_mode)
                        PAR_EVEN: s_nxt.par_bad = s_r.par_acc ^ s_r.level;
                        PAR_ODD:  s_nxt.par_bad = !(s_r.par_acc
                                                    ^ s_r.level);
                        default:  s_nxt.par_bad = 1'b0;
                    endcase
                    s_nxt.state = STOP;
                end
                STOP: begin
                    // Only one stop bit is ever checked.
                    s_nxt.state   = IDLE;
                    done          = 1'b1;
                    new_err[PE_BIT] = s_r.par_bad;
                    new_err[FE_BIT] = !s_r.level;
                    new_err[OVE_BIT] = s_r.buf_full;
                    s_nxt.par_bad = 1'b0;
                    if (!s_r.buf_full) begin
                        s_nxt.rx_buffer_reg = s_r.lsb_first
                            && !s_r.operation_mode_reg[LEN8_BIT]
                            ? {1'b0, s_r.rx_shift_reg[7:1]}
                            : {s_r.operation_mode_reg[LEN8_BIT]
                               & s_r.rx_shift_reg[7],
                               s_r.rx_shift_reg[6:0]};
                        s_nxt.buf_full = 1'b1;
                    end
                end
                BRK: begin
                    // Error checks and buffer transfer stay off here.
                    if (!s_r.level) begin
                        if (s_r.low_cnt != BRK_SAT) begin
                            s_nxt.low_cnt = s_r.low_cnt + 4'h1;
                        end
                    end else if (s_r.low_cnt >= BRK_MIN) begin
                        s_nxt.state            = IDLE;
                        s_nxt.done_irq         = 1'b1;
                        s_nxt.break_rx_trigger = 1'b0;
                        s_nxt.break_rx_flag    = 1'b0;
                    end else begin
                        s_nxt.state = IDLE;
                    end
                end
                default: s_nxt.state = IDLE;
            endcase
        end

        // Request routing; errors may ride on the done request.
        if (done) begin
            if (new_err != 3'h0
                && !s_r.operation_mode_reg[MERGE_BIT]) begin
                s_nxt.err_irq = 1'b1;
            end else begin
                s_nxt.done_irq = 1'b1;
            end
        end

        // Read data and side effects of reads. New errors win a clear.
        unique case (reg_addr_in)
            MODE_OFS:   s_nxt.rdata = s_r.operation_mode_reg;
            ERR_OFS:    s_nxt.rdata = {5'h00, s_r.err};
            BUF_OFS:    s_nxt.rdata = s_r.rx_buffer_reg;
            DIV_OFS:    s_nxt.rdata = s_r.baud_divisor_reg;
            CLKSEL_OFS: s_nxt.rdata = {4'h0, s_r.base_clock_select_reg};
            CTRL_OFS:   s_nxt.rdata = {s_r.break_rx_flag,
                                       s_r.break_rx_trigger, 4'h0,
                                       s_r.lsb_first, 1'b0};
            default:    s_nxt.rdata = 8'h00;
        endcase
        if (!reg_rd_in) begin
            s_nxt.rdata = s_r.rdata;
        end
        s_nxt.err = (rd_err ? 3'h0 : s_r.err) | new_err;
        if (rd_buf && !done) begin
            s_nxt.buf_full = 1'b0;
        end

        // Register writes.
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                MODE_OFS:   s_nxt.operation_mode_reg = reg_wdata_in;
                DIV_OFS:    s_nxt.baud_divisor_reg   = reg_wdata_in;
                CLKSEL_OFS: s_nxt.base_clock_select_reg
                                = reg_wdata_in[3:0];
                CTRL_OFS: begin
                    s_nxt.lsb_first = reg_wdata_in[LSB_BIT];
                    if (enabled) begin
                        s_nxt.break_rx_trigger
                            = reg_wdata_in[BRK_TRIG_BIT];
                    end
                end
                default: ;
            endcase
        end
        // Switching the receiver off ends any break wait.
        if (!enabled) begin
            s_nxt.break_rx_trigger = 1'b0;
            s_nxt.break_rx_flag    = 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            s_r <= '0;
            s_r.level <= 1'b1;
            s_r.samp  <= 1'b1;
            s_r.prev  <= 1'b1;
            s_r.rx_buffer_reg <= BUF_RST;
            s_r.operation_mode_reg <= MODE_RST;
            s_r.baud_divisor_reg <= DIV_RST;
            s_r.base_clock_select_reg <= CLKSEL_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Checks on the receiver.
    off_clear_a: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        !enabled |=> s_r.cnt == 8'h00 && s_r.state == IDLE)
        else $error("counter not cleared while off");
    overrun_keep_a: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        sample_ev && s_r.state == STOP && s_r.buf_full && !rd_err
        |=> $stable(s_r.rx_buffer_reg) && s_r.err[OVE_BIT])
        else $error("overrun overwrote buffer");
    break_hold_a: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        s_r.state == BRK |=> $stable(s_r.rx_buffer_reg)
                           && !s_r.err_irq)
        else $error("buffer changed in break");
    err_clear_a: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        rd_err && !sample_ev |=> s_r.err == 3'h0)
        else $error("error status not cleared by read");
    err_split_a: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        sample_ev && s_r.state == STOP && !s_r.level
        && !s_r.operation_mode_reg[MERGE_BIT]
        |=> s_r.err_irq && !s_r.done_irq)
        else $error("error not on separate request");
    err_merge_a: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        sample_ev && s_r.state == STOP && !s_r.level
        && s_r.operation_mode_reg[MERGE_BIT]
        |=> s_r.done_irq && !s_r.err_irq && s_r.err[FE_BIT])
        else $error("merged error not on done request");
    noise_drop_a: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        sample_ev && s_r.state == START && s_r.level
        |=> s_r.state == IDLE)
        else $error("noise edge taken as start");
    break_short_a: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        sample_ev && s_r.state == BRK && s_r.level
        && s_r.low_cnt < BRK_MIN && !reg_wr_in
        |=> s_r.break_rx_trigger && s_r.break_rx_flag && !s_r.done_irq)
        else $error("short break ended break mode");
    break_ok_a: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        sample_ev && s_r.state == BRK && s_r.level
        && s_r.low_cnt >= BRK_MIN
        |=> s_r.done_irq && !s_r.break_rx_trigger && !s_r.break_rx_flag)
        else $error("long break not completed");
    filter_a: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        enabled && !$stable(s_r.level) |-> $past(s_r.samp) == s_r.level)
        else $error("filter passed a single sample");
    frame_done_c: cover property (
        @(posedge clock_in) disable iff (!rst_n_in) s_r.done_irq);
    frame_err_c: cover property (
        @(posedge clock_in) disable iff (!rst_n_in) s_r.err_irq);
    break_done_c: cover property (
        @(posedge clock_in) disable iff (!rst_n_in)
        $fell(s_r.break_rx_flag) && s_r.done_irq);
endmodule : uart_receiver
`default_nettype wire

// file: sim/serial_node.sv
`timescale 1ns/1ns
`default_nettype none
module serial_node (
    // Clock.
    input  wire logic clock_in,
    // Serial line towards the receiver.
    output var logic  line_out
);
    import uart_rx_pkg::*;

    // The line idles high between frames, as a real node leaves it.
    initial line_out = 1'b1;

    // Hold one level for a number of cycles, changing just after an edge.
    task automatic drive_level(input logic lvl, input int cycles);
        line_out <= lvl;
        repeat (cycles) @(posedge clock_in);
    endtask : drive_level

    // Send one character; parity is formed here so that it can be spoilt.
    task automatic send_frame(input logic [7:0] d, input logic len8,
                              input logic [1:0] par, input logic lsb,
                              input logic bad_par, input logic stop_lvl,
                              input int bc);
        logic [7:0] dm;
        logic       pb;
        int         n;
        dm = len8 ? d : {1'b0, d[6:0]};
        n  = len8 ? 8 : 7;
        pb = (par == PAR_EVEN) ? ^dm : (par == PAR_ODD) ? ~^dm : 1'b0;
        drive_level(1'b0, bc);
        for (int i = 0; i < n; i++) begin
            drive_level(lsb ? dm[i] : dm[n - 1 - i], bc);
        end
        if (par != PAR_NONE) begin
            drive_level(pb ^ bad_par, bc);
        end
        drive_level(stop_lvl, bc);
        // A low stop bit is released so that no false edge follows it.
        if (!stop_lvl) begin
            drive_level(1'b1, bc);
        end
    endtask : send_frame

    // A break is a plain low stretch, sized by the caller in bit times.
    task automatic send_break(input int nbits, input int bc);
        drive_level(1'b0, nbits * bc);
        drive_level(1'b1, 2 * bc);
    endtask : send_break
endmodule : serial_node
`default_nettype wire

// file: sim/uart_receiver_with_break_field_tb.sv
`timescale 1ns/1ns
`default_nettype none
module uart_receiver_with_break_field_tb;
    import uart_rx_pkg::*;

    localparam int BC = 16;
    logic       clock_in = 1'b0;
    logic       rst_n_in = 1'b0;
    logic [2:0] reg_addr_in = 3'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic       reg_wr_in = 1'b0;
    logic       reg_rd_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic       serial_line;
    logic       rx_done_irq_out;
    logic       rx_error_irq_out;
    logic [7:0] done_cnt = 8'h00;
    logic [7:0] err_cnt = 8'h00;
    logic [7:0] done_snap, err_snap;
    logic       merge_sel, lsb_sel;
    int         miscompares = 0;
    int         n_tests = 0;
    int         bc = BC;

    // Base tick at clock rate with divisor 8 gives sixteen cycles a bit.
    always #5 clock_in = ~clock_in;

    uart_receiver u_dut (
        .clock_in         (clock_in),
        .rst_n_in         (rst_n_in),
        .reg_addr_in      (reg_addr_in),
        .reg_wdata_in     (reg_wdata_in),
        .reg_wr_in        (reg_wr_in),
        .reg_rd_in        (reg_rd_in),
        .reg_rdata_out    (reg_rdata_out),
        .serial_in_pin_in (serial_line),
        .rx_done_irq_out  (rx_done_irq_out),
        .rx_error_irq_out (rx_error_irq_out)
    );

    serial_node u_node (
        .clock_in (clock_in),
        .line_out (serial_line)
    );

    // Pulses are counted, so a request that stays high is seen as extra.
    always @(posedge clock_in) begin
        if (rx_done_irq_out === 1'b1) done_cnt <= done_cnt + 8'h01;
        if (rx_error_irq_out === 1'b1) err_cnt <= err_cnt + 8'h01;
    end

    // Print the counts and the verdict, then stop.
    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    // Compare one byte-wide result.
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One write cycle; called just after a rising edge.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
        // One idle edge, so that a following write never raises the
        // strobe in the same time step in which this one lowers it.
        @(posedge clock_in);
    endtask : wr

    // One read cycle; the data stand only in the following cycle.
    task automatic rc(input string nm, input logic [2:0] a,
                      input logic [7:0] e);
        logic [7:0] v;
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
        #1 v = reg_rdata_out;
        @(posedge clock_in);
        chk(nm, e, v);
    endtask : rc

    // Check the requests seen since the last snapshot.
    task automatic irq_chk(input logic [7:0] dd, input logic [7:0] de);
        repeat (4) @(posedge clock_in);
        chk("done_irq", done_snap + dd, done_cnt);
        chk("error_irq", err_snap + de, err_cnt);
    endtask : irq_chk

    // Error status expected for a frame with the given faults.
    function automatic logic [7:0] exp_err(input logic [1:0] p,
                                           input logic bad, input logic stp);
        return {5'h00, bad & p[1], ~stp, 1'b0};
    endfunction : exp_err

    // Receive one frame and check requests, status and buffer.
    task automatic rx(input logic [7:0] d, input logic l8,
                      input logic [1:0] p, input logic bad, input logic stp);
        logic [7:0] e;
        e = exp_err(p, bad, stp);
        done_snap = done_cnt;
        err_snap  = err_cnt;
        u_node.send_frame(d, l8, p, lsb_sel, bad, stp, bc);
        irq_chk({7'h00, e == 8'h00 || merge_sel},
                {7'h00, e != 8'h00 && !merge_sel});
        rc("error", ERR_OFS, e);
        if (e != 8'h00) rc("error", ERR_OFS, 8'h00);
        rc("buffer", BUF_OFS, l8 ? d : {1'b0, d[6:0]});
    endtask : rx

    // Hang guard sized well above the expected run of some 4400 cycles.
    initial begin
        #300000;
        miscompares++;
        close_out();
    end

    // Main sequence.
    initial begin
        logic [7:0] d1;
        logic [1:0] p;
        void'($urandom(32'h2af39246));
        merge_sel = 1'b0;
        lsb_sel   = 1'b0;
        repeat (6) @(posedge clock_in);
        rst_n_in <= 1'b1;
        @(posedge clock_in);
        rc("mode", MODE_OFS, MODE_RST);
        rc("error", ERR_OFS, 8'h00);
        rc("buffer", BUF_OFS, BUF_RST);
        rc("divisor", DIV_OFS, DIV_RST);
        rc("clock select", CLKSEL_OFS, {4'h0, CLKSEL_RST});
        rc("control", CTRL_OFS, 8'h00);
        rc("unmapped", 3'h6, 8'h00);
        wr(DIV_OFS, 8'h08);
        wr(CLKSEL_OFS, 8'h00);
        rc("divisor", DIV_OFS, 8'h08);
        // Power alone must not sample the line nor arm a break.
        wr(MODE_OFS, 8'h84);
        wr(CTRL_OFS, 8'h40);
        rc("control", CTRL_OFS, 8'h00);
        done_snap = done_cnt;
        err_snap  = err_cnt;
        u_node.send_frame(8'h55, 1'b1, PAR_NONE, 1'b0, 1'b0, 1'b1, BC);
        irq_chk(8'h00, 8'h00);
        wr(MODE_OFS, 8'ha4);
        wr(CTRL_OFS, 8'h40);
        rc("control", CTRL_OFS, 8'h40);
        // A ten-bit break is too short and leaves the mode armed.
        done_snap = done_cnt;
        err_snap  = err_cnt;
        u_node.send_break(10, BC);
        irq_chk(8'h00, 8'h00);
        rc("control", CTRL_OFS, 8'hc0);
        done_snap = done_cnt;
        u_node.send_break(11, BC);
        irq_chk(8'h01, 8'h00);
        rc("control", CTRL_OFS, 8'h00);
        rc("error", ERR_OFS, 8'h00);
        rc("buffer", BUF_OFS, BUF_RST);
        // Short glitches must be dropped by the filter or the recheck.
        done_snap = done_cnt;
        err_snap  = err_cnt;
        u_node.drive_level(1'b0, 1);
        u_node.drive_level(1'b1, 40);
        u_node.drive_level(1'b0, 5);
        u_node.drive_level(1'b1, 40);
        irq_chk(8'h00, 8'h00);
        // Every parity mode, clean and spoilt, with random framing.
        for (int i = 0; i < 16; i++) begin
            p         = i[1:0];
            merge_sel = i[3];
            lsb_sel   = 1'($urandom);
            d1        = 8'($urandom);
            wr(MODE_OFS, {3'b101, p, 1'(i[2] ^ i[0]), 1'b0, merge_sel});
            wr(CTRL_OFS, {6'h00, lsb_sel, 1'b0});
            rx(d1, 1'(i[2] ^ i[0]), p, i[2], 1'b1);
        end
        merge_sel = 1'b0;
        wr(MODE_OFS, 8'ha4);
        rx(8'ha5, 1'b1, PAR_NONE, 1'b0, 1'b0);
        // Two frames back to back with one stop bit and no buffer read.
        d1 = 8'($urandom);
        done_snap = done_cnt;
        err_snap  = err_cnt;
        u_node.send_frame(d1, 1'b1, PAR_NONE, lsb_sel, 1'b0, 1'b1, BC);
        u_node.send_frame(~d1, 1'b1, PAR_NONE, lsb_sel, 1'b0, 1'b1, BC);
        irq_chk(8'h01, 8'h01);
        rc("error", ERR_OFS, 8'h01);
        rc("buffer", BUF_OFS, d1);
        // A slower base clock: every second cycle ticks, so a bit doubles.
        wr(CLKSEL_OFS, 8'h01);
        rc("clock select", CLKSEL_OFS, 8'h01);
        bc = 2 * BC;
        rx(8'($urandom), 1'b1, PAR_NONE, 1'b0, 1'b1);
        close_out();
    end
endmodule : uart_receiver_with_break_field_tb
`default_nettype wire
